// ### rtl/nvc_access_ctrl.sv
/*
 * Indirect access controller for the data EEPROM (held inside as an array)
 * and for reads of an external program flash.
 * Assumes register accesses arrive as single-cycle strobes synchronous to clk_in,
 * and that the flash presents its word within the cycle of its read request.
 */
//
// Functional notes
// - Address reaches 256 bytes or 4K words.
// - Data uses low address; program uses both.
// - Bit 7 selects program space; reset clears.
// - Write strobe in program space drops, nothing.
// - Strobes set by software, cleared on completion.
// - Write strobe needs write-enable; hardware keeps it.
// - Clearing write-enable never disturbs running write.
// - Write needs 55h, AAh, then strobe.
// - Unlock location stores nothing, reads zero.
// - Resets during a write set abort flag.
// - Write end clears strobe, sets sticky flag.
// - Data read byte appears next cycle.
// - Program read uses second cycle, fills both.
// - High data holds 6 bits, top zero.
// - High address holds 4 bits, top zero.
// - Data write erases location before programming.
// - Power-up timer blocks writes for 64 ms.
module nvc_access_ctrl
  import nvc_pkg::*;
#(
  parameter int PWRT_CYCLES = nvc_pkg::NVC_PWRT_CYCLES,
  parameter int WRITE_CYCLES = nvc_pkg::NVC_WRITE_CYCLES
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Reset causes that interrupt the core while powered
  input wire logic external_master_reset_in,
  input wire logic watchdog_reset_in,
  input wire logic brownout_reset_in,
  // Register port
  input wire logic [2:0] reg_index_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Write-complete flag toward the peripheral flag register
  input wire logic write_complete_clear_in,
  output logic write_complete_flag_out,
  // Program flash read port
  output logic flash_read_out,
  output logic [nvc_pkg::NVC_PROG_ADDR_WIDTH-1:0] flash_addr_out,
  input wire logic [nvc_pkg::NVC_PROG_WIDTH-1:0] flash_data_in,
  // Core side status
  output logic discard_instruction_out,
  output logic write_busy_out
);
  import nvc_pkg::*;

  // ****************************************
  // Storage and state
  // ****************************************
  logic [7:0] data_mem [NVC_DATA_DEPTH];
  logic [7:0] nv_data_low_reg;
  logic [5:0] nv_data_high_reg;
  logic [7:0] nv_address_low_reg;
  logic [3:0] nv_address_high_reg;
  nvc_ctrl_t ctrl_reg;
  nvc_state_t state_reg;
  logic [1:0] key_stage_reg;
  logic [31:0] pwrt_count_reg;
  logic pwrt_done_reg;
  logic [31:0] write_count_reg;
  logic [7:0] write_addr_reg;
  logic [7:0] write_data_reg;

  // ****************************************
  // Decoded requests
  // ****************************************
  logic wr_data_low;
  logic wr_data_high;
  logic wr_addr_low;
  logic wr_addr_high;
  logic wr_control;
  logic wr_unlock;
  logic core_reset;
  logic set_read;
  logic set_write;
  logic start_write;
  logic write_end;
  logic data_read_done;

  assign wr_data_low = reg_write_in && (reg_index_in == NVC_IDX_DATA_LOW);
  assign wr_data_high = reg_write_in && (reg_index_in == NVC_IDX_DATA_HIGH);
  assign wr_addr_low = reg_write_in && (reg_index_in == NVC_IDX_ADDR_LOW);
  assign wr_addr_high = reg_write_in && (reg_index_in == NVC_IDX_ADDR_HIGH);
  assign wr_control = reg_write_in && (reg_index_in == NVC_IDX_CONTROL);
  assign wr_unlock = reg_write_in && (reg_index_in == NVC_IDX_UNLOCK);
  assign core_reset = external_master_reset_in || watchdog_reset_in || brownout_reset_in;

  // A read strobe may only be raised while no operation is outstanding.
  assign set_read = wr_control && reg_wdata_in[NVC_BIT_READ] && (state_reg == NVC_IDLE)
    && !ctrl_reg.read_strobe && !ctrl_reg.write_strobe && !core_reset;

  // The write strobe needs write-enable already set, data space, the key
  // sequence just completed, and the power-up timer expired.
  assign set_write = wr_control && reg_wdata_in[NVC_BIT_WRITE] && ctrl_reg.write_enable_bit
    && !reg_wdata_in[NVC_BIT_SPACE] && !ctrl_reg.space_select
    && (key_stage_reg == 2'h2)
    && pwrt_done_reg
    && (state_reg == NVC_IDLE) && !ctrl_reg.read_strobe && !core_reset;
  assign start_write = set_write;

  assign write_end = (state_reg == NVC_WRITING) && (write_count_reg == 32'(WRITE_CYCLES - 1));
  assign data_read_done = ctrl_reg.read_strobe && !ctrl_reg.space_select && (state_reg == NVC_IDLE);

  // ****************************************
  // Power-up timer
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pwrt_count_reg <= 32'h0;
      pwrt_done_reg <= 1'b0;
    end
    else if (!pwrt_done_reg)
    begin
      if (pwrt_count_reg == 32'(PWRT_CYCLES - 1))
      begin
        pwrt_done_reg <= 1'b1;
      end
      pwrt_count_reg <= pwrt_count_reg + 32'h1;
    end
  end

  // ****************************************
  // Unlock key detector
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      key_stage_reg <= 2'h0;
    end
    else if (core_reset || write_end || set_write)
    begin
      key_stage_reg <= 2'h0;
    end
    else if (wr_unlock && (key_stage_reg == 2'h0) && (reg_wdata_in == NVC_KEY_FIRST))
    begin
      key_stage_reg <= 2'h1;
    end
    else if (wr_unlock && (key_stage_reg == 2'h1) && (reg_wdata_in == NVC_KEY_SECOND))
    begin
      key_stage_reg <= 2'h2;
    end
    else if (wr_unlock && (reg_wdata_in == NVC_KEY_FIRST))
    begin
      key_stage_reg <= 2'h1;
    end
    else if (reg_write_in)
    begin
      key_stage_reg <= 2'h0;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ctrl_reg <= '0;
    end
    else if (core_reset)
    begin
      ctrl_reg.read_strobe <= 1'b0;
      ctrl_reg.write_strobe <= 1'b0;
      ctrl_reg.write_enable_bit <= 1'b0;
      ctrl_reg.space_select <= 1'b0;
      if (state_reg == NVC_WRITING)
      begin
        ctrl_reg.write_abort_flag <= 1'b1;
      end
    end
    else
    begin
      if (wr_control)
      begin
        ctrl_reg.space_select <= reg_wdata_in[NVC_BIT_SPACE];
        ctrl_reg.write_enable_bit <= reg_wdata_in[NVC_BIT_WRITE_ENABLE_BIT];
        ctrl_reg.write_abort_flag <= reg_wdata_in[NVC_BIT_ABORT];
      end
      if (set_read)
      begin
        ctrl_reg.read_strobe <= 1'b1;
      end
      else if (data_read_done || flash_read_out)
      begin
        ctrl_reg.read_strobe <= 1'b0;
      end
      if (set_write)
      begin
        ctrl_reg.write_strobe <= 1'b1;
      end
      else if (write_end)
      begin
        ctrl_reg.write_strobe <= 1'b0;
      end
    end
  end

  // ****************************************
  // Operation sequencer
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= NVC_IDLE;
      write_count_reg <= 32'h0;
      write_addr_reg <= NVC_BYTE_RESET;
      write_data_reg <= NVC_BYTE_RESET;
    end
    else if (core_reset)
    begin
      state_reg <= NVC_IDLE;
      write_count_reg <= 32'h0;
    end
    else
    begin
      unique case (state_reg)
        NVC_IDLE:
        begin
          write_count_reg <= 32'h0;
          if (start_write)
          begin
            state_reg <= NVC_WRITING;
            write_addr_reg <= nv_address_low_reg;
            write_data_reg <= nv_data_low_reg;
          end
          else if (set_read && reg_wdata_in[NVC_BIT_SPACE])
          begin
            state_reg <= NVC_PROG_FETCH;
          end
        end
        NVC_PROG_FETCH:
        begin
          state_reg <= NVC_IDLE;
        end
        NVC_WRITING:
        begin
          write_count_reg <= write_count_reg + 32'h1;
          if (write_end)
          begin
            state_reg <= NVC_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Data EEPROM array
  // ****************************************
  // The location is erased when the write starts and programmed when it ends,
  // so a write aborted after its first cycle leaves the byte erased.
  always_ff @(posedge clk_in)
  begin
    if ((state_reg == NVC_WRITING) && (write_count_reg == 32'h0) && !core_reset)
    begin
      data_mem[write_addr_reg] <= NVC_ERASED_BYTE;
    end
    else if (write_end && !core_reset)
    begin
      data_mem[write_addr_reg] <= write_data_reg;
    end
  end

  // ****************************************
  // Address and data registers
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      nv_address_low_reg <= NVC_BYTE_RESET;
      nv_address_high_reg <= 4'h0;
    end
    else if (core_reset)
    begin
      nv_address_low_reg <= NVC_BYTE_RESET;
      nv_address_high_reg <= 4'h0;
    end
    else
    begin
      if (wr_addr_low)
      begin
        nv_address_low_reg <= reg_wdata_in;
      end
      if (wr_addr_high)
      begin
        nv_address_high_reg <= reg_wdata_in[3:0];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      nv_data_low_reg <= NVC_BYTE_RESET;
      nv_data_high_reg <= 6'h0;
    end
    else if (core_reset)
    begin
      nv_data_low_reg <= NVC_BYTE_RESET;
      nv_data_high_reg <= 6'h0;
    end
    else if (data_read_done)
    begin
      nv_data_low_reg <= data_mem[nv_address_low_reg];
    end
    else if (flash_read_out)
    begin
      nv_data_low_reg <= flash_data_in[7:0];
      nv_data_high_reg <= flash_data_in[NVC_PROG_WIDTH-1:8];
    end
    else
    begin
      if (wr_data_low)
      begin
        nv_data_low_reg <= reg_wdata_in;
      end
      if (wr_data_high)
      begin
        nv_data_high_reg <= reg_wdata_in[5:0];
      end
    end
  end

  // ****************************************
  // Program flash request
  // ****************************************
  // The instruction right after the strobe runs normally; the flash is asked in
  // the second cycle, and the instruction of that cycle is flagged to be dropped.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      flash_read_out <= 1'b0;
      flash_addr_out <= '0;
      discard_instruction_out <= 1'b0;
    end
    else
    begin
      flash_read_out <= (state_reg == NVC_PROG_FETCH) && !core_reset;
      discard_instruction_out <= (state_reg == NVC_PROG_FETCH) && !core_reset;
      flash_addr_out <= {nv_address_high_reg, nv_address_low_reg};
    end
  end

  // ****************************************
  // Completion flag and status
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      write_complete_flag_out <= 1'b0;
      write_busy_out <= 1'b0;
    end
    else
    begin
      if (write_end && !core_reset)
      begin
        write_complete_flag_out <= 1'b1;
      end
      else if (write_complete_clear_in)
      begin
        write_complete_flag_out <= 1'b0;
      end
      write_busy_out <= (start_write || ((state_reg == NVC_WRITING) && !write_end)) && !core_reset;
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      reg_rdata_out <= NVC_BYTE_RESET;
    end
    else if (reg_read_in)
    begin
      unique case (reg_index_in)
        NVC_IDX_DATA_LOW: reg_rdata_out <= nv_data_low_reg;
        NVC_IDX_DATA_HIGH: reg_rdata_out <= {2'h0, nv_data_high_reg} & NVC_HIGH_DATA_MASK;
        NVC_IDX_ADDR_LOW: reg_rdata_out <= nv_address_low_reg;
        NVC_IDX_ADDR_HIGH: reg_rdata_out <= {4'h0, nv_address_high_reg} & NVC_HIGH_ADDR_MASK;
        NVC_IDX_CONTROL: reg_rdata_out <= {ctrl_reg.space_select, 3'h0, ctrl_reg.write_abort_flag,
          ctrl_reg.write_enable_bit, ctrl_reg.write_strobe, ctrl_reg.read_strobe};
        NVC_IDX_UNLOCK: reg_rdata_out <= NVC_BYTE_RESET;
        default: reg_rdata_out <= NVC_BYTE_RESET;
      endcase
    end
  end

endmodule

// ### rtl/nvc_pkg.sv
/*
 * Shared constants and types for the nonvolatile access controller.
 * Assumes a 100 MHz core clock equal to the instruction cycle.
 */
package nvc_pkg;

  // ****************************************
  // Register indices on the register port
  // ****************************************
  localparam logic [2:0] NVC_IDX_DATA_LOW = 3'h0;
  localparam logic [2:0] NVC_IDX_DATA_HIGH = 3'h1;
  localparam logic [2:0] NVC_IDX_ADDR_LOW = 3'h2;
  localparam logic [2:0] NVC_IDX_ADDR_HIGH = 3'h3;
  localparam logic [2:0] NVC_IDX_CONTROL = 3'h4;
  localparam logic [2:0] NVC_IDX_UNLOCK = 3'h5;

  // ****************************************
  // Control register field positions
  // ****************************************
  localparam int NVC_BIT_READ = 0;
  localparam int NVC_BIT_WRITE = 1;
  localparam int NVC_BIT_WRITE_ENABLE_BIT = 2;
  localparam int NVC_BIT_ABORT = 3;
  localparam int NVC_BIT_SPACE = 7;

  // ****************************************
  // Widths, keys and reset values
  // ****************************************
  localparam int NVC_DATA_DEPTH = 256;
  localparam int NVC_PROG_WIDTH = 14;
  localparam int NVC_PROG_ADDR_WIDTH = 12;
  localparam logic [7:0] NVC_KEY_FIRST = 8'h55;
  localparam logic [7:0] NVC_KEY_SECOND = 8'hAA;
  localparam logic [7:0] NVC_ERASED_BYTE = 8'hFF;
  localparam logic [7:0] NVC_BYTE_RESET = 8'h00;
  localparam logic [7:0] NVC_HIGH_DATA_MASK = 8'h3F;
  localparam logic [7:0] NVC_HIGH_ADDR_MASK = 8'h0F;

  // ****************************************
  // Timing
  // ****************************************
  localparam int NVC_CLOCK_MHZ = 100;
  localparam int NVC_PWRT_MS = 64;
  localparam int NVC_PWRT_CYCLES = NVC_PWRT_MS * 1000 * NVC_CLOCK_MHZ;
  localparam int NVC_WRITE_TIME_US = 5000;
  localparam int NVC_WRITE_CYCLES = NVC_WRITE_TIME_US * NVC_CLOCK_MHZ;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic space_select;
    logic write_abort_flag;
    logic write_enable_bit;
    logic write_strobe;
    logic read_strobe;
  } nvc_ctrl_t;

  typedef enum logic [1:0] {
    NVC_IDLE,
    NVC_PROG_FETCH,
    NVC_WRITING
  } nvc_state_t;

endpackage

// ### tb/nvc_access_ctrl_asserts.sv
/* Port checker for nvc_access_ctrl.
   Bound from tb; WRITE_CYCLES must match the instance. */
module nvc_access_ctrl_asserts
  import nvc_pkg::*;
#(
  parameter int WRITE_CYCLES = 10
)
(
  // Clock, reset and reset events
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic external_master_reset_in,
  input wire logic watchdog_reset_in,
  input wire logic brownout_reset_in,
  // Register port
  input wire logic [2:0] reg_index_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  // Flag, flash and status
  input wire logic write_complete_clear_in,
  input wire logic write_complete_flag_out,
  input wire logic flash_read_out,
  input wire logic [11:0] flash_addr_out,
  input wire logic [13:0] flash_data_in,
  input wire logic discard_instruction_out,
  input wire logic write_busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic any_rst;
  int busy_cnt;
  assign any_rst = external_master_reset_in | watchdog_reset_in | brownout_reset_in;
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      busy_cnt <= 0;
    else if (write_busy_out)
      busy_cnt <= busy_cnt + 1;
    else
      busy_cnt <= 0;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_fetch;
    flash_read_out && discard_instruction_out ##1 !flash_read_out && !discard_instruction_out;
  endsequence
  a_fetch_pulse: assert property ($rose(flash_read_out) |-> s_fetch)
    else $error("fetch pulse wrong");
  a_busy_len_ok: assert property ($fell(write_busy_out) && !$past(any_rst) |->
    busy_cnt == WRITE_CYCLES)
    else $error("write length wrong");
  a_done_sets_flag: assert property ($fell(write_busy_out) && !$past(any_rst) |-> write_complete_flag_out)
    else $error("flag not set at end");
  a_flag_stays_set: assert property (write_complete_flag_out && !write_complete_clear_in |=>
    write_complete_flag_out)
    else $error("flag dropped");
  a_flag_clears: assert property (write_complete_clear_in && !write_busy_out |=> !write_complete_flag_out)
    else $error("flag not cleared");
  a_key_reads_zero: assert property (reg_read_in && reg_index_in == NVC_IDX_UNLOCK |=> reg_rdata_out == 8'h00)
    else $error("key port not zero");
  a_data_high_top: assert property (reg_read_in && reg_index_in == NVC_IDX_DATA_HIGH |=>
    reg_rdata_out[7:6] == 2'h0)
    else $error("data high top set");
  a_addr_high_top: assert property (reg_read_in && reg_index_in == NVC_IDX_ADDR_HIGH |=>
    reg_rdata_out[7:4] == 4'h0)
    else $error("addr high top set");
  a_rdata_holds: assert property (!reg_read_in && !any_rst |=> $stable(reg_rdata_out))
    else $error("read data moved");
endmodule

// ### tb/tb.sv
/* Self-checking bench for nvc_access_ctrl.
   Assumes short power-up and write timers set by parameter. */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import nvc_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic external_master_reset_in = 1'b0;
  logic watchdog_reset_in = 1'b0;
  logic brownout_reset_in = 1'b0;
  logic [2:0] reg_index_in = 3'h0;
  logic reg_write_in = 1'b0;
  logic reg_read_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [7:0] reg_rdata_out;
  logic write_complete_clear_in = 1'b0;
  logic write_complete_flag_out;
  logic flash_read_out;
  logic [11:0] flash_addr_out;
  logic [13:0] flash_data_in = 14'h2A5C;
  logic discard_instruction_out;
  logic write_busy_out;
  int fail_count = 0;
  int check_count = 0;
  always #5 clk_in = ~clk_in;
  nvc_access_ctrl #(.PWRT_CYCLES(20), .WRITE_CYCLES(10)) i_nvc_access_ctrl (
    .clk_in, .rst_n_in, .external_master_reset_in, .watchdog_reset_in, .brownout_reset_in,
    .reg_index_in, .reg_write_in, .reg_read_in, .reg_wdata_in, .reg_rdata_out,
    .write_complete_clear_in, .write_complete_flag_out, .flash_read_out, .flash_addr_out,
    .flash_data_in, .discard_instruction_out, .write_busy_out);
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    @(posedge clk_in);
    reg_index_in <= i;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clk_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic rdchk(input logic [2:0] i, input logic [7:0] e, input string nm);
    @(posedge clk_in);
    reg_index_in <= i;
    reg_read_in <= 1'b1;
    @(posedge clk_in);
    reg_read_in <= 1'b0;
    @(negedge clk_in);
    chk(nm, reg_rdata_out, e);
  endtask
  task automatic unlock;
    wr(NVC_IDX_UNLOCK, NVC_KEY_FIRST);
    wr(NVC_IDX_UNLOCK, NVC_KEY_SECOND);
  endtask
  task automatic arm_write;
    wr(NVC_IDX_CONTROL, 8'h04);
    unlock();
    wr(NVC_IDX_CONTROL, 8'h06);
    @(negedge clk_in);
  endtask
  task automatic wait_idle;
    for (int n = 0; n < 60; n++)
    begin
      @(negedge clk_in);
      if (write_busy_out === 1'b0)
        return;
    end
    fail_count++;
    $display("[FAIL] busy wait expected 0 seen 1");
    print_verdict();
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_start;
    rdchk(NVC_IDX_CONTROL, 8'h00, "ctrl reset");
    arm_write();
    chk("busy early", write_busy_out, 1'b0);
    rdchk(NVC_IDX_CONTROL, 8'h04, "ctrl early");
    for (int i = 0; i < 6; i++)
      if (i != 4)
        rdchk(i[2:0], 8'h00, "reg reset");
  endtask
  task automatic t_write;
    wr(NVC_IDX_ADDR_LOW, 8'h5A);
    wr(NVC_IDX_DATA_LOW, 8'hC3);
    arm_write();
    chk("busy", write_busy_out, 1'b1);
    wr(NVC_IDX_CONTROL, 8'h00);
    rdchk(NVC_IDX_CONTROL, 8'h02, "ctrl mid");
    wait_idle();
    chk("done flag", write_complete_flag_out, 1'b1);
    rdchk(NVC_IDX_CONTROL, 8'h00, "ctrl done");
    wr(NVC_IDX_DATA_LOW, 8'h00);
    wr(NVC_IDX_CONTROL, 8'h01);
    rdchk(NVC_IDX_DATA_LOW, 8'hC3, "readback");
    @(posedge clk_in);
    write_complete_clear_in <= 1'b1;
    @(posedge clk_in);
    write_complete_clear_in <= 1'b0;
    @(negedge clk_in);
    chk("flag clear", write_complete_flag_out, 1'b0);
  endtask
  task automatic t_refuse;
    wr(NVC_IDX_CONTROL, 8'h04);
    wr(NVC_IDX_CONTROL, 8'h06);
    rdchk(NVC_IDX_CONTROL, 8'h04, "no key");
    wr(NVC_IDX_UNLOCK, NVC_KEY_FIRST);
    wr(NVC_IDX_ADDR_LOW, 8'h10);
    wr(NVC_IDX_UNLOCK, NVC_KEY_SECOND);
    wr(NVC_IDX_CONTROL, 8'h06);
    rdchk(NVC_IDX_CONTROL, 8'h04, "broken key");
    wr(NVC_IDX_CONTROL, 8'h00);
    unlock();
    wr(NVC_IDX_CONTROL, 8'h02);
    rdchk(NVC_IDX_CONTROL, 8'h00, "no write_enable_bit");
    wr(NVC_IDX_CONTROL, 8'h84);
    unlock();
    wr(NVC_IDX_CONTROL, 8'h86);
    rdchk(NVC_IDX_CONTROL, 8'h84, "prog write");
    chk("prog busy", write_busy_out, 1'b0);
  endtask
  task automatic t_prog;
    wr(NVC_IDX_ADDR_HIGH, 8'hF3);
    rdchk(NVC_IDX_ADDR_HIGH, 8'h03, "addr high");
    wr(NVC_IDX_ADDR_LOW, 8'h7E);
    wr(NVC_IDX_CONTROL, 8'h81);
    @(negedge clk_in);
    chk("first slot", discard_instruction_out, 1'b0);
    chk("no early fetch", flash_read_out, 1'b0);
    @(negedge clk_in);
    chk("fetch", flash_read_out, 1'b1);
    chk("fetch addr", flash_addr_out, 12'h37E);
    chk("discard", discard_instruction_out, 1'b1);
    rdchk(NVC_IDX_DATA_LOW, 8'h5C, "word low");
    rdchk(NVC_IDX_DATA_HIGH, 8'h2A, "word high");
    rdchk(NVC_IDX_CONTROL, 8'h80, "prog done");
  endtask
  task automatic t_abort(input int k);
    wr(NVC_IDX_ADDR_LOW, 8'h00);
    wr(NVC_IDX_DATA_LOW, 8'h12);
    arm_write();
    @(posedge clk_in);
    external_master_reset_in <= (k == 0);
    watchdog_reset_in <= (k == 1);
    brownout_reset_in <= (k == 2);
    @(posedge clk_in);
    external_master_reset_in <= 1'b0;
    watchdog_reset_in <= 1'b0;
    brownout_reset_in <= 1'b0;
    @(negedge clk_in);
    chk("abort busy", write_busy_out, 1'b0);
    rdchk(NVC_IDX_CONTROL, 8'h08, "abort flag");
    wr(NVC_IDX_CONTROL, 8'h01);
    rdchk(NVC_IDX_DATA_LOW, NVC_ERASED_BYTE, "erased");
    wr(NVC_IDX_CONTROL, 8'h00);
    chk("abort no done", write_complete_flag_out, 1'b0);
  endtask
  initial
  begin
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_start();
    repeat (30) @(posedge clk_in);
    t_write();
    t_refuse();
    t_prog();
    for (int k = 0; k < 3; k++)
      t_abort(k);
    print_verdict();
  end
endmodule
bind nvc_access_ctrl nvc_access_ctrl_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) i_nvc_access_ctrl_asserts (
  .clk_in, .rst_n_in, .external_master_reset_in, .watchdog_reset_in, .brownout_reset_in,
  .reg_index_in, .reg_write_in, .reg_read_in, .reg_wdata_in, .reg_rdata_out,
  .write_complete_clear_in, .write_complete_flag_out, .flash_read_out, .flash_addr_out,
  .flash_data_in, .discard_instruction_out, .write_busy_out);
